// ### shared/acr_pkg.sv
package acr_pkg;

	// bus geometry
	localparam int ACR_AW = 8;
	localparam int ACR_DW = 32;

	// register byte offsets
	localparam logic [ACR_AW-1:0] ACR_OFF_SELECT = 8'h00;
	localparam logic [ACR_AW-1:0] ACR_OFF_STATUS = 8'h04;
	localparam logic [ACR_AW-1:0] ACR_OFF_CAUSE = 8'h08;

	// select register: reset value and the digit that enables code output
	localparam logic [15:0] ACR_SELECT_RST = 16'h0000;
	localparam logic [3:0] ACR_SEL_CODE_ON = 4'h1;

	// bus responses
	localparam logic [1:0] ACR_RESP_OKAY = 2'h0;
	localparam logic [1:0] ACR_RESP_SLVERR = 2'h2;

	// status word field positions
	localparam int ACR_ST_LATCHED = 0;
	localparam int ACR_ST_WARN = 1;
	localparam int ACR_ST_ENABLE = 2;
	localparam int ACR_ST_FAULT = 3;
	localparam int ACR_ST_CODE = 4;
	localparam int ACR_ST_STOP = 8;
	localparam int ACR_ST_DETAIL = 12;
	localparam int ACR_ST_NUMBER = 16;
	localparam int ACR_ST_WNUM = 24;

	// alarm sources, index 0 has the highest priority
	localparam int ACR_NUM_ALM = 6;
	localparam logic [7:0] ACR_ALM_NUM [ACR_NUM_ALM] =
		'{8'h10, 8'h10, 8'h12, 8'h13, 8'h14, 8'h15};
	localparam logic [3:0] ACR_ALM_DET [ACR_NUM_ALM] =
		'{4'h1, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0};
	localparam logic [2:0] ACR_ALM_CODE [ACR_NUM_ALM] =
		'{3'h2, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0};
	localparam logic [ACR_NUM_ALM-1:0] ACR_ALM_SD = 6'h02;
	localparam logic [ACR_NUM_ALM-1:0] ACR_ALM_CLR = 6'h03;

	// stop sequence
	typedef enum logic [1:0] {
		ACR_STOP_RUN,
		ACR_STOP_DECEL,
		ACR_STOP_BRAKE
	} acr_stop_t;

	// axi4-lite master to slave
	typedef struct packed {
		logic awvalid;
		logic [ACR_AW-1:0] awaddr;
		logic wvalid;
		logic [ACR_DW-1:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ACR_AW-1:0] araddr;
		logic rready;
	} acr_axi_req_t;

	// axi4-lite slave to master
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [ACR_DW-1:0] rdata;
		logic [1:0] rresp;
	} acr_axi_rsp_t;

	// whole block state
	typedef struct packed {
		logic latched;
		logic [2:0] idx;
		logic [3:0] detail;
		acr_stop_t stop;
		logic [15:0] sel;
		logic fault;
		logic [2:0] code;
		logic warn_on;
		logic [7:0] disp_num;
		logic [3:0] disp_det;
		logic disp_alarm;
		logic aw_held;
		logic [ACR_AW-1:0] awaddr;
		logic w_held;
		logic [ACR_DW-1:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [ACR_DW-1:0] rdata;
		logic [1:0] rresp;
	} acr_state_t;

	localparam acr_state_t ACR_STATE_RST = '{
		stop: ACR_STOP_RUN,
		sel: ACR_SELECT_RST,
		fault: 1'b1,
		default: '0
	};

endpackage

// ### hdl/acr_top.sv
`timescale 1ns/1ps
module acr_top
	import acr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire acr_axi_req_t s_axi_req,
	output acr_axi_rsp_t s_axi_rsp,
	input wire logic [ACR_NUM_ALM-1:0] alarm_cause,
	input wire logic [3:0] fault_detail,
	input wire logic warn_cause,
	input wire logic [7:0] warn_number,
	input wire logic [3:0] warn_detail,
	input wire logic fault_clear_input,
	input wire logic panel_clear_button,
	input wire logic drive_enable_input,
	input wire logic decel_done,
	output logic fault_output,
	output logic code_bit0,
	output logic code_bit1,
	output logic code_bit2,
	output logic decel_then_brake_stop,
	output logic immediate_brake_stop,
	output logic [7:0] display_number,
	output logic [3:0] display_detail,
	output logic display_is_alarm,
	output logic display_is_warning
);

	acr_state_t s;
	acr_state_t next_s;
	logic [2:0] pick;
	logic any_cause;
	logic cause_gone;
	logic clear_req;
	logic clear_ok;
	logic aw_rdy;
	logic w_rdy;
	logic ar_rdy;
	logic [ACR_DW-1:0] status_word;
	logic [2:0] code_pins;

	// priority pick: lowest index among raised causes
	always_comb begin
		pick = 3'h0;
		for (int i = ACR_NUM_ALM - 1; i >= 0; i--) begin
			if (alarm_cause[i]) begin
				pick = 3'(i);
			end
		end
	end

	// clear qualification: cause gone, method allowed, request present
	assign any_cause = |alarm_cause;
	assign cause_gone = !alarm_cause[s.idx];
	assign clear_req = fault_clear_input || panel_clear_button;
	assign clear_ok = s.latched && cause_gone && ACR_ALM_CLR[s.idx]
		&& clear_req;

	// bus handshake readiness
	assign aw_rdy = !s.aw_held && !s.bvalid;
	assign w_rdy = !s.w_held && !s.bvalid;
	assign ar_rdy = !s.rvalid;

	// status word seen by software
	always_comb begin
		status_word = '0;
		status_word[ACR_ST_LATCHED] = s.latched;
		status_word[ACR_ST_WARN] = s.warn_on;
		status_word[ACR_ST_ENABLE] = drive_enable_input;
		status_word[ACR_ST_FAULT] = s.fault;
		status_word[ACR_ST_CODE +: 3] = s.code;
		status_word[ACR_ST_STOP +: 2] = s.stop;
		status_word[ACR_ST_DETAIL +: 4] = s.detail;
		status_word[ACR_ST_NUMBER +: 8] = ACR_ALM_NUM[s.idx];
		status_word[ACR_ST_WNUM +: 8] = warn_number;
	end

	// next state of the whole block
	always_comb begin
		next_s = s;
		// write address and data are taken independently
		if (s_axi_req.awvalid && aw_rdy) begin
			next_s.aw_held = 1'b1;
			next_s.awaddr = s_axi_req.awaddr;
		end
		if (s_axi_req.wvalid && w_rdy) begin
			next_s.w_held = 1'b1;
			next_s.wdata = s_axi_req.wdata;
			next_s.wstrb = s_axi_req.wstrb;
		end
		if (s.bvalid && s_axi_req.bready) begin
			next_s.bvalid = 1'b0;
		end
		// perform the write once both halves are held
		if (s.aw_held && s.w_held && !s.bvalid) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = ACR_RESP_OKAY;
			case ({s.awaddr[ACR_AW-1:2], 2'b00})
				ACR_OFF_SELECT: begin
					if (s.wstrb[0]) begin
						next_s.sel[7:0] = s.wdata[7:0];
					end
					if (s.wstrb[1]) begin
						next_s.sel[15:8] = s.wdata[15:8];
					end
				end
				ACR_OFF_STATUS, ACR_OFF_CAUSE: begin
					next_s.bresp = ACR_RESP_OKAY; // read only, write ignored
				end
				default: begin
					next_s.bresp = ACR_RESP_SLVERR;
				end
			endcase
		end
		// reads answer one cycle after the address is taken
		if (s.rvalid && s_axi_req.rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_req.arvalid && ar_rdy) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = ACR_RESP_OKAY;
			case ({s_axi_req.araddr[ACR_AW-1:2], 2'b00})
				ACR_OFF_SELECT: begin
					next_s.rdata = {16'h0000, s.sel};
				end
				ACR_OFF_STATUS: begin
					next_s.rdata = status_word;
				end
				ACR_OFF_CAUSE: begin
					next_s.rdata = {26'h0000000, alarm_cause};
				end
				default: begin
					next_s.rdata = '0;
					next_s.rresp = ACR_RESP_SLVERR;
				end
			endcase
		end
		// alarm latch and stop sequence
		if (clear_ok) begin
			next_s.latched = 1'b0;
			next_s.stop = ACR_STOP_RUN;
		end else if (!s.latched && any_cause) begin
			next_s.latched = 1'b1;
			next_s.idx = pick;
			next_s.detail = (ACR_ALM_DET[pick] != 4'h0) ?
				ACR_ALM_DET[pick] : fault_detail;
			if (ACR_ALM_SD[pick]) begin
				next_s.stop = ACR_STOP_DECEL;
			end else begin
				next_s.stop = ACR_STOP_BRAKE;
			end
		end else if (s.stop == ACR_STOP_DECEL && decel_done) begin
			next_s.stop = ACR_STOP_BRAKE;
		end
		// outputs follow the latch, held until clear
		next_s.fault = !next_s.latched;
		if (next_s.latched && next_s.sel[3:0] == ACR_SEL_CODE_ON) begin
			next_s.code = ACR_ALM_CODE[next_s.idx];
		end else begin
			next_s.code = 3'h0;
		end
		// warning tracks its cause directly
		next_s.warn_on = warn_cause;
		// display: alarm first, warning otherwise
		if (next_s.latched) begin
			next_s.disp_alarm = 1'b1;
			next_s.disp_num = ACR_ALM_NUM[next_s.idx];
			next_s.disp_det = next_s.detail;
		end else if (warn_cause) begin
			next_s.disp_alarm = 1'b0;
			next_s.disp_num = warn_number;
			next_s.disp_det = warn_detail;
		end else begin
			next_s.disp_alarm = 1'b0;
			next_s.disp_num = 8'h00;
			next_s.disp_det = 4'h0;
		end
	end

	// state register; reset stands for a power cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= ACR_STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	// code pins, one output per bit
	for (genvar b = 0; b < 3; b++) begin : g_code
		assign code_pins[b] = s.code[b];
	end

	// block outputs
	assign code_bit0 = code_pins[0];
	assign code_bit1 = code_pins[1];
	assign code_bit2 = code_pins[2];
	assign fault_output = s.fault;
	assign decel_then_brake_stop = (s.stop == ACR_STOP_DECEL);
	assign immediate_brake_stop = (s.stop == ACR_STOP_BRAKE);
	assign display_number = s.disp_num;
	assign display_detail = s.disp_det;
	assign display_is_alarm = s.disp_alarm;
	assign display_is_warning = s.warn_on && !s.disp_alarm;

	// bus responses
	assign s_axi_rsp = '{
		awready: aw_rdy,
		wready: w_rdy,
		bvalid: s.bvalid,
		bresp: s.bresp,
		arready: ar_rdy,
		rvalid: s.rvalid,
		rdata: s.rdata,
		rresp: s.rresp
	};

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// a new alarm turns the fault output off on the next edge
	fault_off_a: assert property (
		(!s.latched && any_cause) |=> (!fault_output && s.latched)
	) else $error("fault output not off after alarm");

	// display follows the latched alarm
	display_alarm_a: assert property (
		s.latched |-> (display_is_alarm
			&& display_number == ACR_ALM_NUM[s.idx])
	) else $error("display does not show the alarm");

	// code appears only with the select digit at one
	code_gate_a: assert property (
		(code_pins != 3'h0) |-> (s.latched && s.sel[3:0] == ACR_SEL_CODE_ON)
	) else $error("code driven while not selected");

	// undervoltage gives code 010 when enabled
	uv_code_a: assert property (
		(s.latched && s.idx <= 3'h1 && s.sel[3:0] == ACR_SEL_CODE_ON)
		|-> (!code_bit2 && code_bit1 && !code_bit0)
	) else $error("undervoltage code wrong");

	// no alarm means no code, warnings included
	idle_nocode_a: assert property (
		!s.latched |-> (code_pins == 3'h0)
	) else $error("code driven with no alarm");

	// a warning alone never yields a code
	warn_nocode_a: assert property (
		(warn_cause && !any_cause && !s.latched) |=>
			(code_pins == 3'h0 || $past(s.latched) == 1'b0 && s.latched)
	) else $error("warning produced a code");

	// clearing only once the cause is gone and the method allowed
	clear_gate_a: assert property (
		$past(aresetn) && $fell(s.latched) |->
			$past(cause_gone && ACR_ALM_CLR[s.idx]
			&& clear_req)
	) else $error("alarm cleared without permission");

	// a warning drops one edge after its cause
	warn_drop_a: assert property (
		(!warn_cause && !s.latched) |=> !display_is_warning
	) else $error("warning did not clear itself");

	// decelerate-then-brake: decel first, brake only after decel_done
	decel_first_a: assert property (
		$rose(s.latched) && ACR_ALM_SD[s.idx] |->
			(decel_then_brake_stop && !immediate_brake_stop)
	) else $error("no deceleration before brake");

	// immediate-brake alarms brake at once
	brake_now_a: assert property (
		$rose(s.latched) && !ACR_ALM_SD[s.idx] |->
			(immediate_brake_stop && !decel_then_brake_stop)
	) else $error("immediate brake not applied");

	// power-cycle-only alarms stay latched for good
	power_only_a: assert property (
		(aresetn && s.latched && !ACR_ALM_CLR[s.idx]) |=> s.latched
	) else $error("power-only alarm was cleared");

	// outputs hold while no clear is granted
	hold_latch_a: assert property (
		(aresetn && s.latched && !clear_ok && $stable(s.sel)) |=>
			(!fault_output && ($stable(code_pins) || $changed(s.sel)))
	) else $error("alarm outputs not held");

	// deceleration lasts until the axis reports it has ramped down
	decel_hold_a: assert property (
		(aresetn && decel_then_brake_stop && !decel_done && !clear_ok)
		|=> decel_then_brake_stop
	) else $error("deceleration ended early");

	// end of deceleration hands over to the brake
	decel_brake_a: assert property (
		(aresetn && decel_then_brake_stop && decel_done && !clear_ok)
		|=> (immediate_brake_stop && !decel_then_brake_stop)
	) else $error("brake not applied after deceleration");

	// memory, clock, process and parameter alarms report code 000
	zero_code_a: assert property (
		(s.latched && s.idx >= 3'h2) |-> (code_pins == 3'h0)
	) else $error("code not zero for a code-000 alarm");

	// a granted clear returns every alarm output to idle
	clear_idle_a: assert property (
		(aresetn && clear_ok) |=> (fault_output && code_pins == 3'h0
			&& !decel_then_brake_stop && !immediate_brake_stop)
	) else $error("outputs not idle after a clear");

	// main circuit undervoltage alone starts with a deceleration
	uv_main_decel_a: assert property (
		(aresetn && !s.latched && alarm_cause[1] && !alarm_cause[0])
		|=> (decel_then_brake_stop && !immediate_brake_stop)
	) else $error("main circuit undervoltage did not decelerate");

	// a lone warning reaches the display one edge later
	warn_display_a: assert property (
		(aresetn && warn_cause && !any_cause && !s.latched) |=>
			(display_is_warning && display_number == $past(warn_number))
	) else $error("warning not shown on the display");

endmodule // acr_top

// ### sim/acr_host_model.sv
`timescale 1ns/1ps
module acr_host_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic slow,
	input wire logic fault_output,
	input wire logic decel_then_brake_stop,
	output logic drive_enable_input,
	output logic decel_done
);
	logic [3:0] ramp;
	// host drops drive enable while the fault output is off
	always_ff @(posedge aclk) begin
		drive_enable_input <= !aresetn || fault_output;
	end
	// axis ramp ends after a short or a long deceleration
	always_ff @(posedge aclk) begin
		if (!aresetn || !decel_then_brake_stop) begin
			ramp <= 4'h0;
			decel_done <= 1'b0;
		end else begin
			ramp <= ramp + 4'h1;
			decel_done <= (ramp == (slow ? 4'h8 : 4'h1));
		end
	end
endmodule // acr_host_model

// ### sim/alarm_code_reporter_tb.sv
`timescale 1ns/1ps
module alarm_code_reporter_tb;
	import acr_pkg::*;
	logic aclk, aresetn, slow, warn_cause, fault_clear_input;
	logic panel_clear_button, drive_enable_input, decel_done;
	logic fault_output, code_bit0, code_bit1, code_bit2;
	logic decel_then_brake_stop, immediate_brake_stop;
	logic display_is_alarm, display_is_warning;
	logic [ACR_NUM_ALM-1:0] alarm_cause;
	logic [3:0] fault_detail, warn_detail, display_detail;
	logic [7:0] warn_number, display_number;
	logic [31:0] d;
	logic [1:0] r;
	acr_axi_req_t req;
	acr_axi_rsp_t rsp;
	int err_total, checked, cycles;
	logic [7:0] num_tab [ACR_NUM_ALM] =
		'{8'h10, 8'h10, 8'h12, 8'h13, 8'h14, 8'h15};

	acr_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req),
		.s_axi_rsp(rsp), .alarm_cause(alarm_cause),
		.fault_detail(fault_detail), .warn_cause(warn_cause),
		.warn_number(warn_number), .warn_detail(warn_detail),
		.fault_clear_input(fault_clear_input),
		.panel_clear_button(panel_clear_button),
		.drive_enable_input(drive_enable_input), .decel_done(decel_done),
		.fault_output(fault_output), .code_bit0(code_bit0),
		.code_bit1(code_bit1), .code_bit2(code_bit2),
		.decel_then_brake_stop(decel_then_brake_stop),
		.immediate_brake_stop(immediate_brake_stop),
		.display_number(display_number), .display_detail(display_detail),
		.display_is_alarm(display_is_alarm),
		.display_is_warning(display_is_warning));

	acr_host_model host_u (.aclk(aclk), .aresetn(aresetn), .slow(slow),
		.fault_output(fault_output),
		.decel_then_brake_stop(decel_then_brake_stop),
		.drive_enable_input(drive_enable_input), .decel_done(decel_done));

	// clock and hang guard
	always #4 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_total++;
			final_report();
		end
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// axi writes and reads: handshakes taken at the rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic b_ok;
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= v;
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		b_ok = 1'b0;
		while (!b_ok) begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			b_ok = rsp.bvalid;
			r = rsp.bresp;
		end
		req.bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a);
		logic r_ok;
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		r_ok = 1'b0;
		while (!r_ok) begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			r_ok = rsp.rvalid;
			d = rsp.rdata;
			r = rsp.rresp;
		end
		req.rready <= 1'b0;
		@(posedge aclk);
	endtask

	// compare the discrete outputs mid cycle, return on the next edge
	task automatic outs(input logic f, input logic [2:0] c,
		input logic [1:0] s, input logic [7:0] n);
		@(negedge aclk);
		chk("fault_output", fault_output, f);
		chk("code_bits", {code_bit2, code_bit1, code_bit0}, c);
		chk("stop_outputs", {decel_then_brake_stop, immediate_brake_stop}, s);
		if (!f) chk("display_number", display_number, n);
		@(posedge aclk);
	endtask

	task automatic power_cycle;
		aresetn <= 1'b0;
		@(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		outs(1'b1, 3'h0, 2'b00, 8'h00);
	endtask

	// raise one alarm, follow the stop, try a clear, remove it, then try a clear again
	task automatic run_alarm(input int i, input logic on);
		logic [2:0] c;
		logic [7:0] n;
		logic [3:0] dt;
		c = (on && i < 2) ? 3'h2 : 3'h0;
		dt = (i == 0) ? 4'h1 : ((i == 1) ? 4'h2 : 4'h3);
		n = num_tab[i];
		alarm_cause <= 6'h01 << i;
		@(posedge aclk);
		outs(1'b0, c, (i == 1) ? 2'b10 : 2'b01, n);
		repeat (40) begin
			@(negedge aclk);
			if (immediate_brake_stop === 1'b1) break;
		end
		chk("display_detail", display_detail, dt);
		chk("display_alarm", display_is_alarm, 1'b1);
		@(posedge aclk);
		outs(1'b0, c, 2'b01, n);
		rd(ACR_OFF_STATUS);
		chk("status_number", d[ACR_ST_NUMBER +: 8], n);
		chk("status_enable", d[ACR_ST_ENABLE], 1'b0);
		fault_clear_input <= 1'b1;
		@(posedge aclk);
		outs(1'b0, c, 2'b01, n);
		fault_clear_input <= 1'b0;
		alarm_cause <= '0;
		@(posedge aclk);
		outs(1'b0, c, 2'b01, n);
		if (i % 2 == 1) panel_clear_button <= 1'b1;
		else fault_clear_input <= 1'b1;
		@(posedge aclk);
		fault_clear_input <= 1'b0;
		panel_clear_button <= 1'b0;
		if (i < 2) begin
			outs(1'b1, 3'h0, 2'b00, n);
		end else begin
			outs(1'b0, c, 2'b01, n);
			power_cycle();
			wr(ACR_OFF_SELECT, 32'h1);
		end
	endtask

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		req = '0;
		alarm_cause = '0;
		fault_detail = 4'h3;
		warn_cause = 1'b0;
		warn_number = 8'h00;
		warn_detail = 4'h0;
		fault_clear_input = 1'b0;
		panel_clear_button = 1'b0;
		slow = 1'b0;
		err_total = 0;
		checked = 0;
		cycles = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		outs(1'b1, 3'h0, 2'b00, 8'h00);
		rd(ACR_OFF_SELECT);
		chk("select_reset", d, 32'h0);
		rd(8'h0C);
		chk("unmapped_resp", r, ACR_RESP_SLVERR);
		$display("reset test done");
		wr(ACR_OFF_SELECT, 32'h10);
		chk("select_tens_resp", r, ACR_RESP_OKAY);
		run_alarm(1, 1'b0);
		$display("code output off test done");
		wr(ACR_OFF_SELECT, 32'h1);
		chk("select_resp", r, ACR_RESP_OKAY);
		slow <= 1'b1;
		for (int i = 0; i < ACR_NUM_ALM; i++) run_alarm(i, 1'b1);
		$display("alarm table test done");
		warn_number <= 8'h91;
		warn_detail <= 4'h1;
		warn_cause <= 1'b1;
		@(posedge aclk);
		@(negedge aclk);
		chk("warn_shown", display_is_warning, 1'b1);
		chk("warn_number", display_number, 8'h91);
		chk("warn_detail", display_detail, 4'h1);
		chk("warn_not_alarm", display_is_alarm, 1'b0);
		outs(1'b1, 3'h0, 2'b00, 8'h00);
		warn_cause <= 1'b0;
		@(posedge aclk);
		@(negedge aclk);
		chk("warn_gone", display_is_warning, 1'b0);
		$display("warning test done");
		final_report();
	end
endmodule // alarm_code_reporter_tb
